// file: include/dma_event_pkg.sv
package dma_event_pkg;

    // register bus geometry
    localparam int          ADDR_W               = 8;
    localparam int          DATA_W               = 32;
    localparam int          PTR_W                = 16;

    // register offsets (byte addresses)
    localparam logic [7:0]  EVENT_CONTROL_OFS    = 8'h00;
    localparam logic [7:0]  SOURCE_PROGRESS_OFS  = 8'h04;
    localparam logic [7:0]  DEST_PROGRESS_OFS    = 8'h08;
    localparam logic [7:0]  SOURCE_SIZE_OFS      = 8'h0c;
    localparam logic [7:0]  DEST_SIZE_OFS        = 8'h10;
    localparam logic [7:0]  CELL_SIZE_OFS        = 8'h14;
    localparam logic [7:0]  CHANNEL_CONFIG_OFS   = 8'h18;

    // event control field positions
    localparam int          ENABLE_LSB           = 16;
    localparam int          FLAG_LSB             = 0;
    localparam int          SRC_DONE_BIT         = 7;
    localparam int          SRC_HALF_BIT         = 6;
    localparam int          DST_DONE_BIT         = 5;
    localparam int          DST_HALF_BIT         = 4;
    localparam int          BLOCK_DONE_BIT       = 3;
    localparam int          CELL_DONE_BIT        = 2;
    localparam int          ABORT_BIT            = 1;
    localparam int          ADDR_ERROR_BIT       = 0;

    // channel config field positions
    localparam int          CFG_ENABLE_BIT       = 0;
    localparam int          CFG_PATTERN_BIT      = 1;
    localparam int          CFG_ABORT_EN_BIT     = 2;
    localparam int          CFG_IRQ_LSB          = 8;

    // reset values
    localparam logic [7:0]  FLAGS_RST            = 8'h00;
    localparam logic [7:0]  ENABLES_RST          = 8'h00;
    localparam logic [15:0] PTR_RST              = 16'h0000;
    localparam logic [15:0] SIZE_RST             = 16'h0000;
    localparam logic [7:0]  IRQ_NUM_RST          = 8'h00;
    localparam logic [31:0] RDATA_RST            = 32'h0000_0000;

    // one cycle of events from the data movement engine
    typedef struct packed {
        logic       byte_moved;
        logic       pattern_match;
        logic       addr_error;
        logic       irq_seen;
        logic [7:0] irq_number;
    } engine_event_t;

    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

endpackage : dma_event_pkg

// file: rtl/dma_channel_event_pointers.sv
// Behaviour
// - eight interrupt enables at bits 23..16 of the event control register, reset to zero.
// - eight event flags at bits 7..0 in the same order, reset to zero, zero means nothing pending.
// - the source-done flag (bit 7) sets when the source pointer reaches the source size.
// - the source-half flag (bit 6) sets when the source pointer reaches half the source size.
// - the destination-done flag (bit 5) sets when the destination pointer reaches its size.
// - the destination-half flag (bit 4) sets at half the destination size.
// - the block flag (bit 3) sets after the larger size in bytes moved, or on a pattern match.
// - the cell flag (bit 2) sets each time cell-size bytes have been moved.
// - an interrupt equal to the abort request number aborts the channel and sets bit 1.
// - the address-error flag (bit 0) sets when a source or destination address is invalid.
// - event control bits 31..24 and 15..8 read as zero.
// - the source pointer reads in bits 15..0, resets to zero, upper bits read zero.
// - in pattern detect mode a detected pattern clears the source pointer.
// - the destination pointer high byte sits in bits 15..8, resets to zero, bits above are zero.
// - the destination pointer fills bits 15..0 and counts destination bytes up to 65535.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module dma_channel_event_pointers (
    // clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          rst_n_in,
    // register port
    input  wire dma_event_pkg::reg_req_t       req_in,
    output var  logic [dma_event_pkg::DATA_W-1:0] rd_data_out,
    // data movement engine
    input  wire dma_event_pkg::engine_event_t  event_in,
    output var  logic                          abort_out,
    output var  logic                          channel_active_out,
    // interrupt
    output var  logic                          irq_out
);
    import dma_event_pkg::*;

    // wrapping count step: returns next count and whether the limit was hit
    // the limit is compared after the increment, so a size of zero
    // only wraps after 65536 steps, the full range of the counter
    function automatic logic [16:0] step_count(input logic [15:0] cnt, input logic [15:0] lim);
        logic [15:0] inc;
        inc = cnt + 16'h0001;
        if (inc == lim) begin
            step_count = {1'b1, PTR_RST};
        end else begin
            step_count = {1'b0, inc};
        end
    endfunction : step_count

    // register state
    logic [7:0]  flags_reg,    flags_next;
    logic [7:0]  enables_reg,  enables_next;

    // byte progress, all rewound by a fresh start
    logic [15:0] src_ptr_reg,  src_ptr_next;
    logic [15:0] dst_ptr_reg,  dst_ptr_next;
    logic [15:0] blk_cnt_reg,  blk_cnt_next;
    logic [15:0] cell_cnt_reg, cell_cnt_next;

    // programmed sizes, zero stands for 65536
    logic [15:0] src_size_reg, src_size_next;
    logic [15:0] dst_size_reg, dst_size_next;
    logic [15:0] cell_size_reg, cell_size_next;

    // channel configuration
    logic        active_reg,   active_next;
    logic        pattern_reg,  pattern_next;
    logic        abort_en_reg, abort_en_next;
    logic [7:0]  irq_num_reg,  irq_num_next;

    // registered outputs
    logic [31:0] rdata_reg,    rdata_next;
    logic        irq_reg,      irq_next;
    logic        abort_reg,    abort_next;

    // decoded events
    logic        write_ctrl;
    logic        abort_hit;
    logic        moving;
    logic        pattern_hit;

    // flag set and clear masks
    logic [7:0]  set_vec;
    logic [7:0]  clr_vec;

    // counter limits and steps
    logic [15:0] blk_limit;
    logic [16:0] src_step;
    logic [16:0] dst_step;
    logic [16:0] blk_step;
    logic [16:0] cell_step;

    // event decode shared by the next-state logic and the checks
    always_comb begin
        write_ctrl  = req_in.wr && (req_in.addr == EVENT_CONTROL_OFS);
        // abort only while running and with the match enabled
        abort_hit   = active_reg && abort_en_reg && event_in.irq_seen
                      && (event_in.irq_number == irq_num_reg);
        // an abort cycle moves nothing
        moving      = active_reg && event_in.byte_moved && !abort_hit;
        pattern_hit = active_reg && pattern_reg && event_in.pattern_match && !abort_hit;
        // subtracting one makes a zero size the largest of all
        blk_limit   = (src_size_reg - 16'h0001 >= dst_size_reg - 16'h0001)
                      ? src_size_reg : dst_size_reg; // zero size counts as 65536
        src_step    = step_count(src_ptr_reg, src_size_reg);
        dst_step    = step_count(dst_ptr_reg, dst_size_reg);
        blk_step    = step_count(blk_cnt_reg, blk_limit);
        cell_step   = step_count(cell_cnt_reg, cell_size_reg);
        clr_vec     = write_ctrl ? req_in.wdata[FLAG_LSB +: 8] : 8'h00;
    end

    // next state of the channel, flags and read data
    always_comb begin
        flags_next     = flags_reg;
        enables_next   = enables_reg;
        src_ptr_next   = src_ptr_reg;
        dst_ptr_next   = dst_ptr_reg;
        blk_cnt_next   = blk_cnt_reg;
        cell_cnt_next  = cell_cnt_reg;
        src_size_next  = src_size_reg;
        dst_size_next  = dst_size_reg;
        cell_size_next = cell_size_reg;
        active_next    = active_reg;
        pattern_next   = pattern_reg;
        abort_en_next  = abort_en_reg;
        irq_num_next   = irq_num_reg;
        abort_next     = 1'b0;
        set_vec        = 8'h00;
        rdata_next     = RDATA_RST;

        // register writes
        if (write_ctrl) begin
            enables_next = req_in.wdata[ENABLE_LSB +: 8];
        end else if (req_in.wr && req_in.addr == SOURCE_SIZE_OFS) begin
            src_size_next = req_in.wdata[15:0];
        end else if (req_in.wr && req_in.addr == DEST_SIZE_OFS) begin
            dst_size_next = req_in.wdata[15:0];
        end else if (req_in.wr && req_in.addr == CELL_SIZE_OFS) begin
            cell_size_next = req_in.wdata[15:0];
        end else if (req_in.wr && req_in.addr == CHANNEL_CONFIG_OFS) begin
            active_next   = req_in.wdata[CFG_ENABLE_BIT];
            pattern_next  = req_in.wdata[CFG_PATTERN_BIT];
            abort_en_next = req_in.wdata[CFG_ABORT_EN_BIT];
            irq_num_next  = req_in.wdata[CFG_IRQ_LSB +: 8];
        end

        // a fresh start rewinds all progress
        if (!active_reg && active_next) begin
            src_ptr_next  = PTR_RST;
            dst_ptr_next  = PTR_RST;
            blk_cnt_next  = PTR_RST;
            cell_cnt_next = PTR_RST;
        end

        // byte progress
        if (moving) begin
            src_ptr_next  = src_step[15:0];
            dst_ptr_next  = dst_step[15:0];
            blk_cnt_next  = blk_step[15:0];
            cell_cnt_next = cell_step[15:0];
            set_vec[SRC_DONE_BIT]   = src_step[16];
            set_vec[SRC_HALF_BIT]   = (src_ptr_reg + 16'h0001) == (src_size_reg >> 1);
            set_vec[DST_DONE_BIT]   = dst_step[16];
            set_vec[DST_HALF_BIT]   = (dst_ptr_reg + 16'h0001) == (dst_size_reg >> 1);
            set_vec[BLOCK_DONE_BIT] = blk_step[16];
            set_vec[CELL_DONE_BIT]  = cell_step[16];
        end

        // pattern detect ends the block and rewinds the source
        if (pattern_hit) begin
            src_ptr_next            = PTR_RST;
            blk_cnt_next            = PTR_RST;
            set_vec[BLOCK_DONE_BIT] = 1'b1;
        end

        // abort stops the channel
        if (abort_hit) begin
            active_next        = 1'b0;
            abort_next         = 1'b1;
            set_vec[ABORT_BIT] = 1'b1;
        end

        // address fault reported by the engine
        if (event_in.addr_error) begin
            set_vec[ADDR_ERROR_BIT] = 1'b1;
        end

        // sticky flags, a set in the clearing cycle wins
        flags_next = (flags_reg & ~clr_vec) | set_vec;

        // read data, unmapped addresses read zero
        if (req_in.rd) begin
            if (req_in.addr == EVENT_CONTROL_OFS) begin
                rdata_next = {8'h00, enables_reg, 8'h00, flags_reg};
            end else if (req_in.addr == SOURCE_PROGRESS_OFS) begin
                rdata_next = {16'h0000, src_ptr_reg};
            end else if (req_in.addr == DEST_PROGRESS_OFS) begin
                rdata_next = {16'h0000, dst_ptr_reg};
            end else if (req_in.addr == SOURCE_SIZE_OFS) begin
                rdata_next = {16'h0000, src_size_reg};
            end else if (req_in.addr == DEST_SIZE_OFS) begin
                rdata_next = {16'h0000, dst_size_reg};
            end else if (req_in.addr == CELL_SIZE_OFS) begin
                rdata_next = {16'h0000, cell_size_reg};
            end else if (req_in.addr == CHANNEL_CONFIG_OFS) begin
                rdata_next = {16'h0000, irq_num_reg, 5'h00, abort_en_reg, pattern_reg,
                              active_reg};
            end
        end

        // level interrupt from unmasked flags
        irq_next = |(flags_next & enables_next);
    end

    // state registers
    // synchronous reset puts every register to its reset value
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            flags_reg     <= FLAGS_RST;
            enables_reg   <= ENABLES_RST;
            src_ptr_reg   <= PTR_RST;
            dst_ptr_reg   <= PTR_RST;
            blk_cnt_reg   <= PTR_RST;
            cell_cnt_reg  <= PTR_RST;
            src_size_reg  <= SIZE_RST;
            dst_size_reg  <= SIZE_RST;
            cell_size_reg <= SIZE_RST;
            active_reg    <= 1'b0;
            pattern_reg   <= 1'b0;
            abort_en_reg  <= 1'b0;
            irq_num_reg   <= IRQ_NUM_RST;
            rdata_reg     <= RDATA_RST;
            irq_reg       <= 1'b0;
            abort_reg     <= 1'b0;
        end else begin
            flags_reg     <= flags_next;
            enables_reg   <= enables_next;
            src_ptr_reg   <= src_ptr_next;
            dst_ptr_reg   <= dst_ptr_next;
            blk_cnt_reg   <= blk_cnt_next;
            cell_cnt_reg  <= cell_cnt_next;
            src_size_reg  <= src_size_next;
            dst_size_reg  <= dst_size_next;
            cell_size_reg <= cell_size_next;
            active_reg    <= active_next;
            pattern_reg   <= pattern_next;
            abort_en_reg  <= abort_en_next;
            irq_num_reg   <= irq_num_next;
            rdata_reg     <= rdata_next;
            irq_reg       <= irq_next;
            abort_reg     <= abort_next;
        end
    end

    // outputs straight from flops
    // no logic between a register and its pin
    assign rd_data_out        = rdata_reg;
    assign irq_out            = irq_reg;
    assign abort_out          = abort_reg;
    assign channel_active_out = active_reg;

    // checks, all on the one clock and quiet while reset is low
    // most look one cycle after the request or event they follow; irq_level_a and irq_mask_a check within the same cycle
    default clocking chk_cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);


    // enables follow the control write
    enable_write_a: assert property (write_ctrl |=> enables_reg == $past(req_in.wdata[23:16]))
        else $error("enable bits not written from bits 23..16");

    // end of source
    src_done_a: assert property (moving && (src_ptr_reg + 16'h0001) == src_size_reg
                                 |=> flags_reg[7] && src_ptr_reg == 16'h0000)
        else $error("source done not flagged at end of source");

    // source midpoint
    src_half_a: assert property (moving && (src_ptr_reg + 16'h0001) == (src_size_reg >> 1)
                                 |=> flags_reg[6])
        else $error("source half not flagged at midpoint");

    // end of destination
    dst_done_a: assert property (moving && (dst_ptr_reg + 16'h0001) == dst_size_reg
                                 |=> flags_reg[5] && dst_ptr_reg == 16'h0000)
        else $error("destination done not flagged at end");

    // destination midpoint
    dst_half_a: assert property (moving && (dst_ptr_reg + 16'h0001) == (dst_size_reg >> 1)
                                 |=> flags_reg[4])
        else $error("destination half not flagged at midpoint");

    // cell boundary
    cell_done_a: assert property (moving && (cell_cnt_reg + 16'h0001) == cell_size_reg
                                  |=> flags_reg[2])
        else $error("cell complete not flagged");

    // pattern rewinds the source
    pattern_clear_a: assert property (pattern_hit |=> src_ptr_reg == 16'h0000 && flags_reg[3])
        else $error("pattern did not rewind source or flag block");

    // abort pulse and stop
    abort_stop_a: assert property (abort_hit |=> flags_reg[1] && abort_out && !channel_active_out
                                   ##1 !abort_out)
        else $error("abort not taken in one cycle");

    // address fault
    addr_error_a: assert property (event_in.addr_error |=> flags_reg[0])
        else $error("address error not flagged");

    // control readback
    ctrl_read_a: assert property (req_in.rd && req_in.addr == EVENT_CONTROL_OFS
                                  |=> rd_data_out[31:24] == 8'h00 && rd_data_out[15:8] == 8'h00
                                  && rd_data_out[7:0] == $past(flags_reg))
        else $error("event control read shows reserved bits");

    // destination readback
    ptr_read_a: assert property (req_in.rd && req_in.addr == DEST_PROGRESS_OFS
                                 |=> rd_data_out == {16'h0000, $past(dst_ptr_reg)})
        else $error("destination pointer read wrong");

    // interrupt level
    irq_level_a: assert property (irq_out == |(flags_reg & enables_reg))
        else $error("interrupt level disagrees with flags and enables");

    // flags only drop on a write
    flag_sticky_a: assert property (!write_ctrl |=> (flags_reg & $past(flags_reg))
                                    == $past(flags_reg))
        else $error("flag dropped without a clearing write");

    // read data stands one cycle only
    rdata_idle_a: assert property (!req_in.rd |=> rd_data_out == 32'h0000_0000)
        else $error("read data left standing");

    // source readback
    src_read_a: assert property (req_in.rd && req_in.addr == SOURCE_PROGRESS_OFS
                                 |=> rd_data_out == {16'h0000, $past(src_ptr_reg)})
        else $error("source pointer read wrong");

    // end of block
    block_done_a: assert property (moving && (blk_cnt_reg + 16'h0001) == blk_limit
                                   |=> flags_reg[3])
        else $error("block complete not flagged");

    // enables hold without a write
    enable_hold_a: assert property (!write_ctrl |=> enables_reg == $past(enables_reg))
        else $error("enable bits changed without a write");

    // write one clears
    flag_clear_a: assert property (write_ctrl && set_vec == 8'h00
                                   |=> flags_reg == ($past(flags_reg) & ~$past(clr_vec)))
        else $error("flag clear by one wrong");

    // destination counts up
    dst_count_a: assert property (moving && (dst_ptr_reg + 16'h0001) != dst_size_reg
                                  |=> dst_ptr_reg == $past(dst_ptr_reg) + 16'h0001)
        else $error("destination pointer did not step");

    // source counts up
    src_count_a: assert property (moving && !pattern_hit && (src_ptr_reg + 16'h0001) != src_size_reg
                                  |=> src_ptr_reg == $past(src_ptr_reg) + 16'h0001)
        else $error("source pointer did not step");

    // no abort without a match
    abort_miss_a: assert property (!abort_hit |=> !abort_out)
        else $error("abort pulse without a match");

    // idle channel holds its pointer
    dst_idle_a: assert property (!active_reg && !req_in.wr |=> dst_ptr_reg == $past(dst_ptr_reg))
        else $error("destination pointer moved while idle");

    // all masked means quiet
    irq_mask_a: assert property (enables_reg == 8'h00 |-> !irq_out)
        else $error("interrupt raised while all masked");

endmodule : dma_channel_event_pointers

`default_nettype wire

// file: tb/dma_engine_model.sv
`timescale 1ns/1ps
`default_nettype none

module dma_engine_model (
    // clock
    input  wire logic                         clk_in,
    // events toward the channel
    output var  dma_event_pkg::engine_event_t event_out
);
    import dma_event_pkg::*;

    // quiet engine at time zero
    initial begin
        event_out = '0;
    end

    // one byte per cycle, back to back, then idle
    task automatic move_bytes(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            event_out.byte_moved <= 1'b1;
        end
        @(posedge clk_in);
        event_out.byte_moved <= 1'b0;
    endtask : move_bytes

    // one-cycle pulse: kind is {byte, pattern, addr error, irq seen}
    task automatic pulse(input logic [3:0] kind, input logic [7:0] num);
        @(posedge clk_in);
        event_out <= {kind, num};
        @(posedge clk_in);
        event_out <= {4'h0, ~num};  // stale number is not left on the lines
    endtask : pulse
endmodule : dma_engine_model
`default_nettype wire

// file: tb/tb_dma_channel_event_pointers.sv
`timescale 1ns/1ps
`default_nettype none

module tb_dma_channel_event_pointers;
    import dma_event_pkg::*;
    logic          clk_in;
    logic          rst_n_in;
    reg_req_t      req_in;
    logic [31:0]   rd_data_out;
    engine_event_t event_in;
    logic          abort_out;
    logic          channel_active_out;
    logic          irq_out;
    int            n_fail;
    int            check_count;
    int            cycles;
    int            ss, ds, cs, n;
    logic [31:0]   seed;
    logic [31:0]   got;
    logic [7:0]    f;
    logic [7:0]    num;

    dma_channel_event_pointers dut (
        .clk_in             (clk_in),
        .rst_n_in           (rst_n_in),
        .req_in             (req_in),
        .rd_data_out        (rd_data_out),
        .event_in           (event_in),
        .abort_out          (abort_out),
        .channel_active_out (channel_active_out),
        .irq_out            (irq_out)
    );
    dma_engine_model eng (
        .clk_in    (clk_in),
        .event_out (event_in)
    );

    // 10 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // flags expected after n bytes from a rewound channel
    function automatic logic [7:0] exp_flags(input int ss, input int ds, input int cs, input int n);
        logic [7:0] e;
        int         mx;
        e = 8'h00;
        mx = (ss > ds) ? ss : ds;
        for (int k = 1; k <= n; k++) begin
            if (k % ss == 0) e[7] = 1'b1;
            if (k % ss == ss / 2) e[6] = 1'b1;
            if (k % ds == 0) e[5] = 1'b1;
            if (k % ds == ds / 2) e[4] = 1'b1;
            if (k % mx == 0) e[3] = 1'b1;
            if (k % cs == 0) e[2] = 1'b1;
        end
        return e;
    endfunction : exp_flags

    // compare and count
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one-cycle register write
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        req_in.wr <= 1'b0;
    endtask : wr_reg

    // one-cycle register read, data taken in the following cycle
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        req_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        req_in.rd <= 1'b0;
        #1 d = rd_data_out;
    endtask : rd_reg

    // report and stop
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    // main sequence
    initial begin
        rst_n_in = 1'b0;
        req_in = '0;
        seed = 32'd80111;
        n_fail = 0;
        check_count = 0;
        cycles = 0;
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd_reg(EVENT_CONTROL_OFS, got);
        chk("event control at reset", 32'h0, got);
        rd_reg(SOURCE_PROGRESS_OFS, got);
        chk("source pointer at reset", 32'h0, got);
        rd_reg(DEST_PROGRESS_OFS, got);
        chk("dest pointer at reset", 32'h0, got);
        rd_reg(8'h40, got);
        chk("unmapped read", 32'h0, got);
        chk("irq at reset", 32'h0, {31'h0, irq_out});
        wr_reg(EVENT_CONTROL_OFS, 32'hffff_ffff);
        rd_reg(EVENT_CONTROL_OFS, got);
        chk("enables only", 32'h00ff_0000, got);
        // random transfers from a rewound channel
        for (int r = 0; r < 24; r++) begin
            seed = lfsr(seed);
            ss = 2 + int'(seed[3:0]);
            ds = 2 + int'(seed[7:4]);
            cs = 1 + int'(seed[10:8]);
            n = (r == 0) ? ss : int'(seed[15:11]) + int'(seed[17:16]);
            wr_reg(CHANNEL_CONFIG_OFS, 32'h0);
            wr_reg(SOURCE_SIZE_OFS, ss);
            wr_reg(DEST_SIZE_OFS, ds);
            wr_reg(CELL_SIZE_OFS, cs);
            wr_reg(CHANNEL_CONFIG_OFS, 32'h1);
            wr_reg(EVENT_CONTROL_OFS, 32'h00ff_00ff);
            eng.move_bytes(n);
            f = exp_flags(ss, ds, cs, n);
            rd_reg(EVENT_CONTROL_OFS, got);
            chk("flags", {16'h00ff, 8'h00, f}, got);
            rd_reg(SOURCE_PROGRESS_OFS, got);
            chk("source pointer", n % ss, got);
            rd_reg(DEST_PROGRESS_OFS, got);
            chk("dest pointer", n % ds, got);
            chk("irq", {31'h0, |f}, {31'h0, irq_out});
            chk("active", 32'h1, {31'h0, channel_active_out});
        end
        // masking, sticky flags and clearing by one
        wr_reg(CHANNEL_CONFIG_OFS, 32'h0);
        wr_reg(SOURCE_SIZE_OFS, 32'h4);
        wr_reg(DEST_SIZE_OFS, 32'h4);
        wr_reg(CELL_SIZE_OFS, 32'h2);
        wr_reg(CHANNEL_CONFIG_OFS, 32'h1);
        eng.move_bytes(4);
        wr_reg(EVENT_CONTROL_OFS, 32'h0);
        rd_reg(EVENT_CONTROL_OFS, got);
        chk("masked flags", 32'h0000_00fc, got);
        chk("masked irq", 32'h0, {31'h0, irq_out});
        wr_reg(EVENT_CONTROL_OFS, 32'h00ff_0080);
        rd_reg(EVENT_CONTROL_OFS, got);
        chk("one flag cleared", 32'h00ff_007c, got);
        chk("unmasked irq", 32'h1, {31'h0, irq_out});
        // pattern detect rewinds the source pointer and ends the block
        wr_reg(CHANNEL_CONFIG_OFS, 32'h0);
        wr_reg(SOURCE_SIZE_OFS, 32'h8);
        wr_reg(DEST_SIZE_OFS, 32'h8);
        wr_reg(CELL_SIZE_OFS, 32'h7);
        wr_reg(CHANNEL_CONFIG_OFS, 32'h3);
        wr_reg(EVENT_CONTROL_OFS, 32'h00ff_00ff);
        eng.move_bytes(5);
        eng.pulse(4'h4, 8'h00);
        rd_reg(SOURCE_PROGRESS_OFS, got);
        chk("source pointer after pattern", 32'h0, got);
        rd_reg(EVENT_CONTROL_OFS, got);
        chk("pattern flags", 32'h00ff_0058, got);
        // abort only on the programmed request number
        seed = lfsr(seed);
        num = seed[7:0];
        wr_reg(CHANNEL_CONFIG_OFS, {16'h0, num, 8'h05});
        wr_reg(EVENT_CONTROL_OFS, 32'h00ff_00ff);
        eng.pulse(4'h1, num ^ 8'h01);
        #1 chk("abort on other irq", 32'h0, {31'h0, abort_out});
        eng.pulse(4'h1, num);
        #1 chk("abort pulse", 32'h1, {31'h0, abort_out});
        @(posedge clk_in);
        #1 chk("abort pulse end", 32'h0, {31'h0, abort_out});
        chk("channel stopped", 32'h0, {31'h0, channel_active_out});
        rd_reg(EVENT_CONTROL_OFS, got);
        chk("abort flag", 32'h00ff_0002, got);
        // address error while idle
        wr_reg(EVENT_CONTROL_OFS, 32'h00ff_00ff);
        eng.pulse(4'h2, 8'h00);
        rd_reg(EVENT_CONTROL_OFS, got);
        chk("address error flag", 32'h00ff_0001, got);
        give_verdict();
    end
endmodule : tb_dma_channel_event_pointers
`default_nettype wire
